// ===== hw/tws_slave.sv
// Two-wire slave unit: address recognition, slave receive and transmit, APB registers.
// Assumes an APB master on clk and a bus master driving SCL; pins are open drain.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tws_slave #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic arb_lost,
	output logic master_start,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	logic rst_meta_reg;
	logic rst_n;
	logic scl_rise, scl_fall, start_det, stop_det, sda_s, bus_busy;
	logic [7:0] shreg;
	logic [3:0] cnt;
	logic sh_clr, sh_load;
	tws_pkg::tws_state_t state_reg, state_next;
	logic flag_reg, flag_next, ack_reg, ack_next, sta_reg, sta_next;
	logic sto_reg, sto_next, wcol_reg, wcol_next, en_reg, en_next, ie_reg, ie_next;
	logic [tws_pkg::PRESC_W-1:0] presc_reg, presc_next;
	logic [7:0] own_reg, own_next, data_reg, data_next, status_reg, status_next;
	logic sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
	logic tx_reg, tx_next, gc_reg, gc_next, arb_reg, arb_next;
	logic drop_reg, drop_next, rs_reg, rs_next, last_reg, last_next, ackgo_reg, ackgo_next;
	logic pend_reg, pend_next, mstart_reg, mstart_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr, mapped, flag_clear, resp, addressed, own_hit, gc_hit, m_ack;

	////////////////////////////////////////////////////////////////////////////////
	// Reset is released through two flip-flops.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and byte shifter.
	tws_line_mon u_mon (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.scl_pin(scl_in),
		.sda_pin(sda_in),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det),
		.sda_s(sda_s),
		.bus_busy(bus_busy)
	);

	tws_shifter #(.W(8)) u_shift (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.clr(sh_clr),
		.load(sh_load),
		.load_data(data_reg),
		.rise(scl_rise),
		.sda_in(sda_s),
		.shreg(shreg),
		.cnt(cnt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup phase.
	always_comb begin
		wr = psel & penable & pwrite;
		mapped = (paddr == ADDR_W'(tws_pkg::OFS_CTRL)) || (paddr == ADDR_W'(tws_pkg::OFS_STAT))
			|| (paddr == ADDR_W'(tws_pkg::OFS_OWN)) || (paddr == ADDR_W'(tws_pkg::OFS_DATA));
		pready = 1'b1;
		pslverr = psel & penable & ~mapped;
		rdata_next = rdata_reg;
		if (psel && !penable) begin
			rdata_next = 32'h0;
			if (paddr == ADDR_W'(tws_pkg::OFS_CTRL)) begin
				rdata_next[7:0] = {flag_reg, ack_reg, sta_reg, sto_reg, wcol_reg, en_reg, 1'b0, ie_reg};
			end else if (paddr == ADDR_W'(tws_pkg::OFS_STAT)) begin
				rdata_next[7:0] = status_reg | {6'h00, presc_reg};
			end else if (paddr == ADDR_W'(tws_pkg::OFS_OWN)) begin
				rdata_next[7:0] = own_reg;
			end else if (paddr == ADDR_W'(tws_pkg::OFS_DATA)) begin
				rdata_next[7:0] = data_reg;
			end
		end
	end

	// Read data register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0;
		end else if (ce) begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slave sequencer; software effects come first so a hardware flag set wins.
	always_comb begin
		state_next = state_reg;
		flag_next = flag_reg;
		ack_next = ack_reg;
		sta_next = sta_reg;
		sto_next = sto_reg;
		wcol_next = wcol_reg;
		en_next = en_reg;
		ie_next = ie_reg;
		presc_next = presc_reg;
		own_next = own_reg;
		data_next = data_reg;
		status_next = status_reg;
		sda_oe_next = sda_oe_reg;
		tx_next = tx_reg;
		gc_next = gc_reg;
		arb_next = arb_reg | arb_lost;
		drop_next = drop_reg;
		rs_next = rs_reg;
		last_next = last_reg;
		ackgo_next = ackgo_reg;
		pend_next = pend_reg;
		mstart_next = 1'b0;
		sh_clr = 1'b0;
		sh_load = 1'b0;
		flag_clear = 1'b0;
		addressed = (state_reg == tws_pkg::S_RX) || (state_reg == tws_pkg::S_TX)
			|| ((state_reg == tws_pkg::S_WAIT) && !drop_reg);
		// Address match uses the live acknowledge and general-call bits.
		own_hit = ack_reg && (shreg[7:1] == own_reg[7:1]);
		gc_hit = ack_reg && own_reg[tws_pkg::OWN_GCE] && (shreg == tws_pkg::GEN_CALL_ADDR);
		m_ack = ~shreg[0];
		if (wr && paddr == ADDR_W'(tws_pkg::OFS_CTRL)) begin
			ack_next = pwdata[tws_pkg::CTL_ACK];
			sta_next = pwdata[tws_pkg::CTL_STA];
			sto_next = pwdata[tws_pkg::CTL_STO];
			en_next = pwdata[tws_pkg::CTL_EN];
			ie_next = pwdata[tws_pkg::CTL_IE];
			flag_clear = pwdata[tws_pkg::CTL_FLAG];
		end
		if (wr && paddr == ADDR_W'(tws_pkg::OFS_STAT)) begin
			presc_next = pwdata[tws_pkg::PRESC_W-1:0];
		end
		if (wr && paddr == ADDR_W'(tws_pkg::OFS_OWN)) begin
			own_next = pwdata[7:0];
		end
		// The data register is writable only while the flag is set.
		if (wr && paddr == ADDR_W'(tws_pkg::OFS_DATA)) begin
			if (flag_reg) begin
				data_next = pwdata[7:0];
				wcol_next = 1'b0;
			end else begin
				wcol_next = 1'b1;
			end
		end
		if (flag_clear) begin
			flag_next = 1'b0;
		end
		resp = flag_clear && flag_reg && (state_reg == tws_pkg::S_WAIT);
		// A pending START goes to the master unit once the bus is free.
		if (pend_reg && !bus_busy) begin
			pend_next = 1'b0;
			sta_next = 1'b0;
			mstart_next = 1'b1;
		end
		if (!en_reg) begin
			state_next = tws_pkg::S_IDLE;
			sda_oe_next = 1'b0;
		end else if ((start_det || stop_det) && addressed && !flag_reg) begin
			flag_next = 1'b1;
			status_next = tws_pkg::ST_STOP;
			state_next = tws_pkg::S_WAIT;
			drop_next = 1'b1;
			rs_next = start_det;
			sda_oe_next = 1'b0;
			sh_clr = 1'b1;
		end else if (start_det && (state_reg != tws_pkg::S_WAIT)) begin
			state_next = tws_pkg::S_ADDR;
			sda_oe_next = 1'b0;
			sh_clr = 1'b1;
		end else if (stop_det && (state_reg != tws_pkg::S_WAIT)) begin
			state_next = tws_pkg::S_IDLE;
			sda_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				tws_pkg::S_IDLE, tws_pkg::S_SKIP: begin
					sda_oe_next = 1'b0;
				end
				tws_pkg::S_ADDR: begin
					if (scl_fall && cnt == tws_pkg::BYTE_BITS) begin
						if (own_hit || gc_hit) begin
							sda_oe_next = 1'b1;
							tx_next = shreg[0] & ~gc_hit;
							gc_next = gc_hit;
						end else begin
							state_next = tws_pkg::S_SKIP;
						end
					end else if (scl_fall && cnt == tws_pkg::ACK_SLOT) begin
						sda_oe_next = 1'b0;
						flag_next = 1'b1;
						if (tx_reg) begin
							status_next = arb_reg ? tws_pkg::ST_ARB_SLA_R : tws_pkg::ST_SLA_R;
						end else if (gc_reg) begin
							status_next = arb_reg ? tws_pkg::ST_ARB_GC : tws_pkg::ST_GC;
						end else begin
							status_next = arb_reg ? tws_pkg::ST_ARB_SLA_W : tws_pkg::ST_SLA_W;
						end
						arb_next = arb_lost;
						drop_next = 1'b0;
						state_next = tws_pkg::S_WAIT;
						sh_clr = 1'b1;
					end
				end
				tws_pkg::S_RX: begin
					if (scl_fall && cnt == tws_pkg::BYTE_BITS) begin
						sda_oe_next = ackgo_reg;
						data_next = shreg; // Whole byte, taken before the ack bit shifts in.
					end else if (scl_fall && cnt == tws_pkg::ACK_SLOT) begin
						sda_oe_next = 1'b0;
						flag_next = 1'b1;
						if (ackgo_reg) begin
							status_next = gc_reg ? tws_pkg::ST_GC_ACK : tws_pkg::ST_RX_ACK;
						end else begin
							status_next = gc_reg ? tws_pkg::ST_GC_NACK : tws_pkg::ST_RX_NACK;
						end
						drop_next = ~ackgo_reg;
						rs_next = 1'b0;
						state_next = tws_pkg::S_WAIT;
						sh_clr = 1'b1;
					end
				end
				tws_pkg::S_TX: begin
					if (scl_fall && cnt != 4'h0 && cnt < tws_pkg::BYTE_BITS) begin
						sda_oe_next = ~shreg[7];
					end else if (scl_fall && cnt == tws_pkg::BYTE_BITS) begin
						sda_oe_next = 1'b0;
					end else if (scl_fall && cnt == tws_pkg::ACK_SLOT) begin
						flag_next = 1'b1;
						if (!m_ack) begin
							status_next = tws_pkg::ST_TX_NACK;
						end else if (last_reg) begin
							status_next = tws_pkg::ST_TX_LAST;
						end else begin
							status_next = tws_pkg::ST_TX_ACK;
						end
						drop_next = last_reg | ~m_ack;
						rs_next = 1'b0;
						state_next = tws_pkg::S_WAIT;
						sh_clr = 1'b1;
					end
				end
				tws_pkg::S_WAIT: begin
					if (resp) begin
						status_next = tws_pkg::ST_NONE;
						if (drop_reg) begin
							// Not addressed; recognition follows the acknowledge bit written now.
							if (rs_reg) begin
								state_next = tws_pkg::S_ADDR;
							end else begin
								state_next = bus_busy ? tws_pkg::S_SKIP : tws_pkg::S_IDLE;
							end
							pend_next = pwdata[tws_pkg::CTL_STA];
						end else if (tx_reg) begin
							sh_load = 1'b1;
							sda_oe_next = ~data_reg[7];
							last_next = ~pwdata[tws_pkg::CTL_ACK];
							state_next = tws_pkg::S_TX;
						end else begin
							ackgo_next = pwdata[tws_pkg::CTL_ACK];
							state_next = tws_pkg::S_RX;
						end
					end
				end
				default: begin
					state_next = tws_pkg::S_IDLE;
					sda_oe_next = 1'b0;
				end
			endcase
		end
		// SCL is stretched while the flag is set in a slave state.
		scl_oe_next = flag_next & en_next;
	end

	// Sequencer and register state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= tws_pkg::S_IDLE;
			flag_reg <= 1'b0;
			ack_reg <= 1'b0;
			sta_reg <= 1'b0;
			sto_reg <= 1'b0;
			wcol_reg <= 1'b0;
			en_reg <= 1'b0;
			ie_reg <= 1'b0;
			presc_reg <= '0;
			own_reg <= tws_pkg::OWN_RST;
			data_reg <= tws_pkg::DATA_RST;
			status_reg <= tws_pkg::ST_NONE;
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			tx_reg <= 1'b0;
			gc_reg <= 1'b0;
			arb_reg <= 1'b0;
			drop_reg <= 1'b0;
			rs_reg <= 1'b0;
			last_reg <= 1'b0;
			ackgo_reg <= 1'b0;
			pend_reg <= 1'b0;
			mstart_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			flag_reg <= flag_next;
			ack_reg <= ack_next;
			sta_reg <= sta_next;
			sto_reg <= sto_next;
			wcol_reg <= wcol_next;
			en_reg <= en_next;
			ie_reg <= ie_next;
			presc_reg <= presc_next;
			own_reg <= own_next;
			data_reg <= data_next;
			status_reg <= status_next;
			sda_oe_reg <= sda_oe_next;
			scl_oe_reg <= scl_oe_next;
			tx_reg <= tx_next;
			gc_reg <= gc_next;
			arb_reg <= arb_next;
			drop_reg <= drop_next;
			rs_reg <= rs_next;
			last_reg <= last_next;
			ackgo_reg <= ackgo_next;
			pend_reg <= pend_next;
			mstart_reg <= mstart_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; open-drain pins only ever pull low.
	assign prdata = rdata_reg;
	assign master_start = mstart_reg;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;

endmodule
`default_nettype wire

// ===== hw/tws_pkg.sv
// Constants, register map and status codes of the two-wire slave unit.
// Assumes an APB master on the register side and a two-wire bus master on the pins.
//
// What this block does
// - General-call byte acked: report 0x90, next byte acked per acknowledge_enable.
// - Byte answered NOT ACK reports 0x88/0x98; after flag clear, not addressed.
// - STOP or repeated START while addressed reports 0xA0; response leaves addressed state.
// - Leaving with acknowledge_enable zero: neither own address nor general call recognised.
// - Leaving with acknowledge_enable one: own address, general call only if enabled.
// - start_request written with leaving response: START once the bus is free.
// - Upper seven address bits compared; bit 0 enables general call address 0x00.
// - Own or enabled general call address; direction one transmits, zero receives.
// - Address plus direction acknowledged: flag set and valid status shown.
// - Arbitration lost then addressed for read: transmit and report 0xB0.
// - Acknowledge cleared while transmitting: last byte, then 0xC0 on NACK, 0xC8 on ACK.
// - After last byte, not addressed; master clocking on reads ones.
// - Master ACK after the last byte reports 0xC8.
// - Acknowledge zero ignores own address but bus stays monitored.
// - Own-address byte acked reports 0x80, next byte acked per acknowledge_enable.
// - Transmitter sends data register byte and expects ACK, or NACK after last.
// - With acknowledge set, SCL stays low from address ack until flag cleared.
package tws_pkg;

	// Register byte addresses.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_OWN = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;

	// Field positions of interface_control.
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK = 6;
	localparam int CTL_STA = 5;
	localparam int CTL_STO = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_EN = 2;
	localparam int CTL_IE = 0;

	// Field positions of own_slave_address and the status register.
	localparam int OWN_GCE = 0;
	localparam int PRESC_W = 2;

	// Reset values.
	localparam logic [7:0] OWN_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'hFF;

	// Status codes with the prescaler bits at zero.
	localparam logic [7:0] ST_NONE = 8'hF8;
	localparam logic [7:0] ST_SLA_W = 8'h60;
	localparam logic [7:0] ST_ARB_SLA_W = 8'h68;
	localparam logic [7:0] ST_GC = 8'h70;
	localparam logic [7:0] ST_ARB_GC = 8'h78;
	localparam logic [7:0] ST_RX_ACK = 8'h80;
	localparam logic [7:0] ST_RX_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_STOP = 8'hA0;
	localparam logic [7:0] ST_SLA_R = 8'hA8;
	localparam logic [7:0] ST_ARB_SLA_R = 8'hB0;
	localparam logic [7:0] ST_TX_ACK = 8'hB8;
	localparam logic [7:0] ST_TX_NACK = 8'hC0;
	localparam logic [7:0] ST_TX_LAST = 8'hC8;

	// Bus constants and bit-slot counts within one byte frame.
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;

	// One-hot slave states.
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_ADDR = 6'b000010,
		S_RX = 6'b000100,
		S_TX = 6'b001000,
		S_WAIT = 6'b010000,
		S_SKIP = 6'b100000
	} tws_state_t;

endpackage

// ===== hw/tws_line_mon.sv
// Synchroniser and bus-condition detector for the SCL and SDA pins.
// Assumes both pins are asynchronous and change slowly against clk.
`timescale 1ns/1ps
`default_nettype none
module tws_line_mon (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det,
	output logic sda_s,
	output logic bus_busy
);

	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] prev_reg;
	logic busy_reg;
	logic busy_next;

	////////////////////////////////////////////////////////////////////////////////
	// Edge and condition decode, seen only on the second synchroniser stage.
	always_comb begin
		scl_rise = sync_reg[0] & ~prev_reg[0];
		scl_fall = ~sync_reg[0] & prev_reg[0];
		start_det = sync_reg[0] & prev_reg[0] & ~sync_reg[1] & prev_reg[1];
		stop_det = sync_reg[0] & prev_reg[0] & sync_reg[1] & ~prev_reg[1];
		sda_s = sync_reg[1];
		busy_next = busy_reg;
		if (start_det) begin
			busy_next = 1'b1;
		end else if (stop_det) begin
			busy_next = 1'b0;
		end
		bus_busy = busy_reg;
	end

	// Two-stage synchroniser; bit 0 is SCL, bit 1 is SDA, both idle high.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
			busy_reg <= 1'b0;
		end else if (ce) begin
			meta_reg <= {sda_pin, scl_pin};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			busy_reg <= busy_next;
		end
	end

endmodule
`default_nettype wire

// ===== hw/tws_shifter.sv
// Byte shift register and bit-slot counter shared by receive and transmit.
// Assumes rise is a one-cycle pulse per SCL rising edge, sda_in synchronised.
`timescale 1ns/1ps
`default_nettype none
module tws_shifter #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic clr,
	input wire logic load,
	input wire logic [W-1:0] load_data,
	input wire logic rise,
	input wire logic sda_in,
	output logic [W-1:0] shreg,
	output logic [3:0] cnt
);

	logic [W-1:0] sh_next;
	logic [3:0] cnt_next;

	////////////////////////////////////////////////////////////////////////////////
	// Sample on each SCL rise; the MSB is the bit driven during the next low phase.
	always_comb begin
		sh_next = shreg;
		cnt_next = cnt;
		if (load) begin
			sh_next = load_data;
			cnt_next = 4'h0;
		end else if (clr) begin
			cnt_next = 4'h0;
		end else if (rise) begin
			sh_next = {shreg[W-2:0], sda_in};
			cnt_next = (cnt == 4'hF) ? cnt : 4'(cnt + 4'h1);
		end
	end

	// State registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= '0;
			cnt <= 4'h0;
		end else if (ce) begin
			shreg <= sh_next;
			cnt <= cnt_next;
		end
	end

endmodule
`default_nettype wire

// ===== bench/tws_slave_monitor.sv
// Concurrent checks on the two-wire slave ports.
// Assumes scl_in and sda_in carry the resolved open-drain line levels.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_monitor #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic arb_lost,
	input wire logic master_start,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	logic acc, mapped, clr_wr, end_rd, quiet_reg, quiet_next, sda_q_reg;
	////////////////////////////////////////////////////////////////////////////
	// Decodes an access, a flag clear and a read of a closing status.
	assign acc = psel && penable;
	assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
	assign clr_wr = acc && pwrite && paddr == tws_pkg::OFS_CTRL && pwdata[tws_pkg::CTL_FLAG];
	assign end_rd = acc && !pwrite && paddr == tws_pkg::OFS_STAT
		&& {prdata[7:3], 3'b000} inside {8'h88, 8'h98, 8'hC0, 8'hC8};
	// Marks the span from a closing status to the next START.
	always_comb begin
		quiet_next = quiet_reg;
		if (scl_in && sda_q_reg && !sda_in) begin
			quiet_next = 1'b0;
		end else if (end_rd) begin
			quiet_next = 1'b1;
		end
	end
	// Registers the marker and the previous SDA level.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			quiet_reg <= 1'b0;
			sda_q_reg <= 1'b1;
		end else begin
			quiet_reg <= quiet_next;
			sda_q_reg <= sda_in;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access without ready");
	property p_err; acc |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("error response wrong for address");
	property p_hold; scl_oe && !clr_wr && !$past(clr_wr) |=> scl_oe; endproperty
	a_hold: assert property (p_hold) else $error("SCL let go before flag clear");
	property p_release; clr_wr && scl_oe |-> ##[1:2] !scl_oe; endproperty
	a_release: assert property (p_release) else $error("SCL still held after clear");
	property p_flag; acc && !pwrite && paddr == 8'h00 && prdata[7] |-> scl_oe; endproperty
	a_flag: assert property (p_flag) else $error("flag set but SCL free");
	property p_sda_edge; $changed(sda_oe) |-> !scl_in; endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("SDA moved while SCL high");
	property p_start_free; master_start |-> scl_in && sda_in ##1 !master_start; endproperty
	a_start_free: assert property (p_start_free) else $error("start request on busy bus");
	property p_quiet; quiet_reg |-> !sda_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("SDA driven when not addressed");
	property p_od; scl_oe || sda_oe |-> !scl_out && !sda_out; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
endmodule
bind tws_slave tws_slave_monitor #(.ADDR_W(ADDR_W)) tws_slave_monitor_inst (.clk(clk),
	.rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .arb_lost(arb_lost),
	.master_start(master_start), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ===== bench/tws_bus_master.sv
// Behavioural two-wire bus master for the bench.
// Assumes both lines are resolved open drain with pull-ups outside.
`timescale 1ns/1ps
`default_nettype none
module tws_bus_master (
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	output logic stuck
);
	// Both lines start released, so the bus idles high.
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		stuck = 1'b0;
	end
	// Lets SCL go and waits, bounded, while the slave stretches it.
	task automatic rel_scl();
		int n = 0;
		scl_low = 1'b0;
		#1;
		while (scl !== 1'b1 && n < 5000) begin
			#40;
			n++;
		end
		if (n >= 5000) stuck = 1'b1;
	endtask
	// One bit slot: 200 ns low, then high until the next fall.
	task automatic bit_slot(input logic drive_low, output logic seen);
		scl_low = 1'b1;
		#40 sda_low = drive_low;
		#160 rel_scl();
		#100 seen = sda;
		#20 scl_low = 1'b1;
	endtask
	// START, also usable as a repeated START from a low SCL.
	task automatic start();
		sda_low = 1'b0;
		#40 rel_scl();
		#80 sda_low = 1'b1;
		#80 scl_low = 1'b1;
	endtask
	// STOP followed by bus free time.
	task automatic stop();
		#40 sda_low = 1'b1;
		#160 rel_scl();
		#80 sda_low = 1'b0;
		#200;
	endtask
	// Eight bits MSB first, then the acknowledge slot.
	task automatic xfer(input logic [7:0] tx, input logic ack_m, output logic [7:0] rx,
		output logic ack_seen);
		for (int i = 7; i >= 0; i--) begin
			bit_slot(!tx[i], rx[i]);
		end
		bit_slot(ack_m, ack_seen);
	endtask
endmodule
`default_nettype wire

// ===== bench/tws_slave_bench.sv
// Self-checking bench for the two-wire slave unit.
// Assumes the design, the master model and the bound monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic arb_lost = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] starts = 8'h00, rx, d;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, q;
	logic pready, pslverr, master_start, scl_oe, sda_oe, m_scl, m_sda, stuck, ab, err;
	logic scl_w, sda_w;
	logic [6:0] own;
	int seed, fail_count, cmp_count;
	////////////////////////////////////////////////////////////////////////////
	// Open-drain lines with pull-ups, and the clock.
	assign scl_w = !(scl_oe || m_scl);
	assign sda_w = !(sda_oe || m_sda);
	always #20 clk = !clk;
	// Counts start requests.
	always @(negedge clk) if (master_start === 1'b1) starts <= starts + 8'h01;
	tws_slave #(.ADDR_W(8)) tws_slave_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .arb_lost(arb_lost), .master_start(master_start),
		.scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
	tws_bus_master tws_bus_master_inst (.scl(scl_w), .sda(sda_w), .scl_low(m_scl),
		.sda_low(m_sda), .stuck(stuck));
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		final_report();
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; read data lands in q, the error bit in err.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) hang();
	endtask
	task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(what, exp, q[7:0]);
	endtask
	// Polls the flag, then compares the status byte, prescaler bits included.
	task automatic wait_stat(input logic [7:0] exp);
		int n = 0;
		do begin
			apb(1'b0, tws_pkg::OFS_CTRL, 8'h00);
			n++;
		end while (q[tws_pkg::CTL_FLAG] !== 1'b1 && n < 400);
		if (n >= 400) hang();
		rd(tws_pkg::OFS_STAT, "status", exp);
	endtask
	// Optional START, one byte slot, and the acknowledge level seen.
	task automatic put(input logic st, input logic [7:0] tx, input logic mk, input logic [7:0] ea);
		if (st) tws_bus_master_inst.start();
		tws_bus_master_inst.xfer(tx, mk, rx, ab);
		chk("ack bit", ea, {7'h00, ab});
	endtask
	function automatic logic [7:0] rx_code(input logic gc, input logic acked);
		if (gc) return acked ? tws_pkg::ST_GC_ACK : tws_pkg::ST_GC_NACK;
		return acked ? tws_pkg::ST_RX_ACK : tws_pkg::ST_RX_NACK;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Cuts a hang short.
	initial begin
		#4000000;
		hang();
	end
	// Main sequence.
	initial begin
		seed = 46862;
		fail_count = 0;
		cmp_count = 0;
		own = 7'($random(seed)) | 7'h01;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(tws_pkg::OFS_DATA, "data", tws_pkg::DATA_RST);
		rd(tws_pkg::OFS_OWN, "own", tws_pkg::OWN_RST);
		rd(tws_pkg::OFS_STAT, "status", tws_pkg::ST_NONE);
		rd(8'h10, "unmapped", 8'h00);
		chk("slverr", 8'h01, {7'h00, err});
		apb(1'b1, tws_pkg::OFS_OWN, {own, 1'b1});
		apb(1'b1, tws_pkg::OFS_CTRL, 8'h44);
		for (int gc = 0; gc < 2; gc++) begin
			put(1'b1, gc ? 8'h00 : {own, 1'b0}, 1'b0, 8'h00);
			wait_stat(gc ? tws_pkg::ST_GC : tws_pkg::ST_SLA_W);
			apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
			d = 8'($random(seed));
			put(1'b0, d, 1'b0, 8'h00);
			wait_stat(rx_code(gc[0], 1'b1));
			rd(tws_pkg::OFS_DATA, "rx byte", d);
			apb(1'b1, tws_pkg::OFS_CTRL, 8'h84);
			put(1'b0, ~d, 1'b0, 8'h01);
			wait_stat(rx_code(gc[0], 1'b0));
			apb(1'b1, tws_pkg::OFS_CTRL, gc ? 8'hE4 : 8'hC4);
			put(1'b0, d, 1'b0, 8'h01);
			tws_bus_master_inst.stop();
		end
		put(1'b1, {own, 1'b0}, 1'b0, 8'h00);
		wait_stat(tws_pkg::ST_SLA_W);
		apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
		tws_bus_master_inst.start();
		wait_stat(tws_pkg::ST_STOP);
		apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
		for (int mk = 0; mk < 2; mk++) begin
			if (mk) begin
				@(posedge clk) arb_lost <= 1'b1;
				@(posedge clk) arb_lost <= 1'b0;
			end
			put(mk[0], {own, 1'b1}, 1'b0, 8'h00);
			wait_stat(mk ? tws_pkg::ST_ARB_SLA_R : tws_pkg::ST_SLA_R);
			d = 8'($random(seed));
			apb(1'b1, tws_pkg::OFS_DATA, d);
			apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
			put(1'b0, 8'hFF, 1'b1, 8'h00);
			chk("tx byte", d, rx);
			wait_stat(tws_pkg::ST_TX_ACK);
			apb(1'b1, tws_pkg::OFS_DATA, ~d);
			apb(1'b1, tws_pkg::OFS_CTRL, 8'h84);
			put(1'b0, 8'hFF, mk[0], {7'h00, !mk[0]});
			chk("last byte", ~d, rx);
			wait_stat(mk ? tws_pkg::ST_TX_LAST : tws_pkg::ST_TX_NACK);
			apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
			put(1'b0, 8'hFF, 1'b0, 8'h01);
			chk("after last", 8'hFF, rx);
			tws_bus_master_inst.stop();
		end
		apb(1'b1, tws_pkg::OFS_CTRL, 8'h84);
		put(1'b1, {own, 1'b0}, 1'b0, 8'h01);
		tws_bus_master_inst.stop();
		apb(1'b1, tws_pkg::OFS_OWN, {own, 1'b0});
		apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
		put(1'b1, 8'h00, 1'b0, 8'h01);
		put(1'b1, {own, 1'b0}, 1'b0, 8'h00);
		wait_stat(tws_pkg::ST_SLA_W);
		apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
		tws_bus_master_inst.stop();
		wait_stat(tws_pkg::ST_STOP);
		apb(1'b1, tws_pkg::OFS_CTRL, 8'hC4);
		chk("start pulses", 8'h01, starts);
		chk("stretch", 8'h00, {7'h00, stuck});
		final_report();
	end
endmodule
`default_nettype wire
